// ==== core/sar_adc_sequencer.sv ====
// Converter sequencer: registers, power control and conversion loop
//
// Operation
// R1 - Result is ten bits: upper eight in high register, lower two in low.
// R2 - Three-bit channel select picks one of up to seven analog inputs.
// R3 - Converter-on powers converter and converts the channel continuously.
// R4 - Each completed conversion sets done flag and loads both result registers.
// R5 - Done flag clears on high result read or any control register write.
// R6 - Software for ten bits polls done, reads low, then high.
// R7 - Software for eight bits polls done, then reads high only.
// R8 - Channel change aborts conversion, clears done flag, restarts new channel.
// R9 - Input above upper reference gives all ones, no overflow flag.
// R10 - Input below lower reference gives zero in both registers.
// R11 - Gain select bit in low register routes input through x8 amplifier.
// R12 - Amplifier powers with converter-on, no extra start-up delay.
// R13 - Clearing converter-on powers down converter and stops conversions.
// R14 - Wait mode has no effect on the converter.
// R15 - Halt disables converter; a stabilisation delay follows wake-up.
// R16 - Analog pins stay readable as logic inputs.
// R17 - Completion raises no request of its own; software polls done. Here a completion raises irq when the done enable bit is set.
// R18 - Fixed-length conversion, one bit per step, registers update together.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sar_adc_sequencer (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Low-power modes
   input wire logic wait_mode,
   input wire logic halt_mode,
   // Analog front end
   input wire logic comp_in,
   input wire logic [6:0] pin_in,
   output logic adc_power,
   output logic amp_en,
   output logic [2:0] chan_sel,
   output logic sample_hold,
   output logic [9:0] dac_code,
   // Interrupt
   output logic irq
);
   sar_if sar ();

   logic on_reg;
   logic [2:0] ch_reg;
   logic eoc_reg;
   logic gain_reg;
   logic [7:0] res_high_reg;
   logic [1:0] res_low_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_en_reg;
   logic irq_reg;
   logic [7:0] rdata_reg;
   sar_adc_pkg::pwr_state_t pwr_reg;
   logic [5:0] stab_reg;
   logic [1:0] div_reg;
   logic tick_reg;
   logic comp_meta;
   logic comp_sync;
   logic [6:0] pin_meta;
   logic [6:0] pin_sync;
   logic start_reg;
   logic abort_reg;
   logic adc_power_reg;
   logic amp_en_reg;
   logic wr_ctrl;
   logic rd_high;
   logic ch_change;
   logic accept;
   logic [1:0] irq_set;
   logic pwr_up;

   sar_engine engine (
      .clk(clk),
      .sys_rst(sys_rst),
      .bus(sar.engine)
   );

   assign sar.start = start_reg;
   assign sar.abort = abort_reg;
   assign sar.tick = tick_reg;
   assign sar.comp = comp_sync;

   assign rdata = rdata_reg;
   assign adc_power = adc_power_reg;
   assign amp_en = amp_en_reg;
   assign chan_sel = ch_reg; // see R2
   assign sample_hold = sar.sampling;
   assign dac_code = sar.code;
   assign irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Decode

   assign wr_ctrl = wr && (addr == sar_adc_pkg::ADDR_CTRL);
   assign rd_high = rd && (addr == sar_adc_pkg::ADDR_RES_HIGH);
   assign ch_change = wr_ctrl && (wdata[2:0] != ch_reg);
   // Completion of a conversion that is being aborted is dropped
   assign accept = sar.done && !ch_change && !abort_reg; // see R8
   assign pwr_up = (pwr_reg == sar_adc_pkg::PWR_RUN) || (pwr_reg == sar_adc_pkg::PWR_STAB);
   assign irq_set[sar_adc_pkg::IRQ_DONE_BIT] = accept;
   assign irq_set[sar_adc_pkg::IRQ_ABORT_BIT] = ch_change && sar.busy;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
         pin_meta <= 7'h00;
         pin_sync <= 7'h00;
      end else begin
         comp_meta <= comp_in;
         comp_sync <= comp_meta;
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software registers

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         on_reg <= 1'b0;
         ch_reg <= sar_adc_pkg::CH_RST;
         gain_reg <= 1'b0;
         irq_en_reg <= sar_adc_pkg::IRQ_RST;
      end else if (wr) begin
         if (addr == sar_adc_pkg::ADDR_CTRL) begin
            on_reg <= wdata[sar_adc_pkg::CTRL_ON_BIT];
            ch_reg <= wdata[2:0];
         end else if (addr == sar_adc_pkg::ADDR_RES_LOW) begin
            gain_reg <= wdata[sar_adc_pkg::LOW_GAIN_BIT]; // see R11
         end else if (addr == sar_adc_pkg::ADDR_IRQ_ENABLE) begin
            irq_en_reg <= wdata[1:0];
         end
      end
   end

   // Done flag for polling; hardware set wins over the clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         eoc_reg <= 1'b0;
      end else if (accept) begin
         eoc_reg <= 1'b1; // see R4 R17
      end else if (wr_ctrl || rd_high) begin
         eoc_reg <= 1'b0; // see R5 R8
      end
   end

   // Both halves load in the same edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         res_high_reg <= sar_adc_pkg::BYTE_RST;
         res_low_reg <= 2'h0;
      end else if (accept) begin
         res_high_reg <= sar.result[9:2]; // see R1 R18
         res_low_reg <= sar.result[1:0];
      end
   end

   // Sticky event bits, write-one-to-clear, set wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status_reg <= sar_adc_pkg::IRQ_RST;
         irq_reg <= 1'b0;
      end else begin
         if (wr && (addr == sar_adc_pkg::ADDR_IRQ_CLEAR)) begin
            irq_status_reg <= (irq_status_reg & ~wdata[1:0]) | irq_set;
         end else begin
            irq_status_reg <= irq_status_reg | irq_set;
         end
         irq_reg <= |(irq_status_reg & irq_en_reg);
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= sar_adc_pkg::BYTE_RST;
      end else if (!rd) begin
         rdata_reg <= sar_adc_pkg::BYTE_RST;
      end else if (addr == sar_adc_pkg::ADDR_CTRL) begin
         rdata_reg <= {eoc_reg, 1'b0, on_reg, 2'h0, ch_reg};
      end else if (addr == sar_adc_pkg::ADDR_RES_HIGH) begin
         rdata_reg <= res_high_reg;
      end else if (addr == sar_adc_pkg::ADDR_RES_LOW) begin
         rdata_reg <= {3'h0, gain_reg, 2'h0, res_low_reg};
      end else if (addr == sar_adc_pkg::ADDR_PINS) begin
         rdata_reg <= {1'b0, pin_sync}; // see R16
      end else if (addr == sar_adc_pkg::ADDR_IRQ_STATUS) begin
         rdata_reg <= {6'h00, irq_status_reg};
      end else if (addr == sar_adc_pkg::ADDR_IRQ_ENABLE) begin
         rdata_reg <= {6'h00, irq_en_reg};
      end else begin
         rdata_reg <= sar_adc_pkg::BYTE_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power sequencing; wait mode is deliberately not an input here

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_reg <= sar_adc_pkg::PWR_OFF;
         stab_reg <= 6'h00;
      end else begin
         case (pwr_reg)
            sar_adc_pkg::PWR_OFF: begin
               if (on_reg && halt_mode) begin
                  pwr_reg <= sar_adc_pkg::PWR_HALTED;
               end else if (on_reg) begin
                  pwr_reg <= sar_adc_pkg::PWR_RUN; // see R3
               end
            end
            sar_adc_pkg::PWR_HALTED: begin
               stab_reg <= 6'h00;
               if (!halt_mode) begin
                  pwr_reg <= on_reg ? sar_adc_pkg::PWR_STAB : sar_adc_pkg::PWR_OFF;
               end
            end
            sar_adc_pkg::PWR_STAB: begin
               if (!on_reg) begin
                  pwr_reg <= sar_adc_pkg::PWR_OFF;
               end else if (halt_mode) begin
                  pwr_reg <= sar_adc_pkg::PWR_HALTED;
               end else if (stab_reg == sar_adc_pkg::STAB_LAST) begin
                  pwr_reg <= sar_adc_pkg::PWR_RUN; // see R15
               end else begin
                  stab_reg <= stab_reg + 6'h01;
               end
            end
            sar_adc_pkg::PWR_RUN: begin
               if (!on_reg) begin
                  pwr_reg <= sar_adc_pkg::PWR_OFF; // see R13
               end else if (halt_mode) begin
                  pwr_reg <= sar_adc_pkg::PWR_HALTED; // see R15
               end
            end
            default: pwr_reg <= sar_adc_pkg::PWR_OFF;
         endcase
      end
   end

   // Amplifier shares the converter supply enable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         adc_power_reg <= 1'b0;
         amp_en_reg <= 1'b0;
      end else begin
         adc_power_reg <= pwr_up; // see R13
         amp_en_reg <= pwr_up && gain_reg; // see R11 R12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter tick and conversion loop

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_reg <= 2'h0;
         tick_reg <= 1'b0;
      end else begin
         div_reg <= (div_reg == sar_adc_pkg::DIV_LAST) ? 2'h0 : div_reg + 2'h1;
         tick_reg <= (div_reg == sar_adc_pkg::DIV_LAST);
      end
   end

   // Restart as soon as the engine goes idle while running
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         start_reg <= 1'b0;
         abort_reg <= 1'b0;
      end else begin
         start_reg <= (pwr_reg == sar_adc_pkg::PWR_RUN) && !sar.busy && !start_reg
                      && !ch_change; // see R3
         abort_reg <= ch_change || (pwr_reg != sar_adc_pkg::PWR_RUN); // see R8 R13
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   done_sets_a: assert property (accept |=> eoc_reg) // see R4
      else $error("done flag not set after completion");
   done_clears_a: assert property ((rd_high || wr_ctrl) && !accept |=> !eoc_reg) // see R5
      else $error("done flag not cleared by read or write");
   result_split_a: assert property (accept |=> res_high_reg == $past(sar.result[9:2]) // see R1
      && res_low_reg == $past(sar.result[1:0]))
      else $error("result halves wrong");
   chan_abort_a: assert property (ch_change |=> abort_reg ##1 !sar.busy) // see R8
      else $error("channel change did not abort");
   halt_off_a: assert property (halt_mode |=> !pwr_up) // see R15
      else $error("converter powered in halt");
   off_stops_a: assert property (!on_reg [*3] |=> !sar.busy && !adc_power_reg) // see R13
      else $error("converter running while off");
   amp_power_a: assert property (amp_en_reg |-> adc_power_reg && $past(gain_reg)) // see R12
      else $error("amplifier on without converter");
   wait_free_a: assert property ($rose(wait_mode) && pwr_reg == sar_adc_pkg::PWR_RUN // see R14
      && on_reg && !halt_mode |=> pwr_reg == sar_adc_pkg::PWR_RUN)
      else $error("wait mode disturbed converter");
   keeps_running_a: assert property (pwr_reg == sar_adc_pkg::PWR_RUN && !sar.busy // see R3
      && !abort_reg |-> ##[1:3] sar.busy || pwr_reg != sar_adc_pkg::PWR_RUN || abort_reg)
      else $error("conversion not restarted");
endmodule : sar_adc_sequencer

// ==== core/sar_adc_pkg.sv ====
// Constants, register map and types of the converter sequencer
package sar_adc_pkg;
   // Timing
   localparam int CLK_NS = 100;
   localparam int STAB_NS = 4000;
   localparam int STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_DIV = 4;
   localparam int SAMPLE_TICKS = 3;
   localparam int RES_BITS = 10;
   localparam logic [1:0] DIV_LAST = 2'(CONV_DIV - 1);
   localparam logic [1:0] SAMPLE_LAST = 2'(SAMPLE_TICKS - 1);
   localparam logic [3:0] MSB_IDX = 4'(RES_BITS - 1);
   localparam logic [5:0] STAB_LAST = 6'(STAB_CYC - 1);
   // Register offsets
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_RES_HIGH = 3'h1;
   localparam logic [2:0] ADDR_RES_LOW = 3'h2;
   localparam logic [2:0] ADDR_PINS = 3'h3;
   localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
   localparam logic [2:0] ADDR_IRQ_CLEAR = 3'h5;
   localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h6;
   // Field positions
   localparam int CTRL_EOC_BIT = 7;
   localparam int CTRL_ON_BIT = 5;
   localparam int LOW_GAIN_BIT = 4;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ABORT_BIT = 1;
   // Reset values
   localparam logic [2:0] CH_RST = 3'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic [9:0] CODE_RST = 10'h000;

   typedef enum {ENG_IDLE, ENG_SAMPLE, ENG_CONVERT} eng_state_t;
   typedef enum {PWR_OFF, PWR_HALTED, PWR_STAB, PWR_RUN} pwr_state_t;

   // One-hot weight of a result bit
   function automatic logic [9:0] bit_mask(input logic [3:0] idx);
      bit_mask = 10'h001 << idx;
   endfunction : bit_mask
endpackage : sar_adc_pkg

// ==== core/sar_if.sv ====
// Signals between the sequencer and its approximation engine
`timescale 1ns/1ps
interface sar_if;
   logic start;
   logic abort;
   logic tick;
   logic comp;
   logic busy;
   logic sampling;
   logic done;
   logic [9:0] code;
   logic [9:0] result;
   modport ctrl (output start, abort, tick, comp,
                 input busy, sampling, done, code, result);
   modport engine (input start, abort, tick, comp,
                   output busy, sampling, done, code, result);
endinterface : sar_if

// ==== core/sar_engine.sv ====
// Successive approximation engine, one result bit per converter tick
`timescale 1ns/1ps
module sar_engine (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Sequencer side
   sar_if.engine bus
);
   sar_adc_pkg::eng_state_t state_reg;
   logic [1:0] cnt_reg;
   logic [3:0] idx_reg;
   logic [9:0] code_reg;
   logic [9:0] kept;
   logic done_reg;
   logic [9:0] result_reg;

   assign bus.busy = (state_reg != sar_adc_pkg::ENG_IDLE);
   assign bus.sampling = (state_reg == sar_adc_pkg::ENG_SAMPLE);
   assign bus.code = code_reg;
   assign bus.done = done_reg;
   assign bus.result = result_reg;

   // Trial bit stays only while input is at or above it
   // Input above range keeps every bit, below range drops all
   assign kept = bus.comp ? code_reg : (code_reg & ~sar_adc_pkg::bit_mask(idx_reg)); // see R9 R10

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= sar_adc_pkg::ENG_IDLE;
         cnt_reg <= 2'h0;
         idx_reg <= 4'h0;
         code_reg <= sar_adc_pkg::CODE_RST;
         done_reg <= 1'b0;
         result_reg <= sar_adc_pkg::CODE_RST;
      end else begin
         done_reg <= 1'b0;
         if (bus.abort) begin
            state_reg <= sar_adc_pkg::ENG_IDLE;
            code_reg <= sar_adc_pkg::CODE_RST;
         end else begin
            case (state_reg)
               sar_adc_pkg::ENG_IDLE: begin
                  if (bus.start) begin
                     state_reg <= sar_adc_pkg::ENG_SAMPLE;
                     cnt_reg <= 2'h0;
                  end
               end
               sar_adc_pkg::ENG_SAMPLE: begin
                  if (bus.tick) begin
                     if (cnt_reg == sar_adc_pkg::SAMPLE_LAST) begin
                        state_reg <= sar_adc_pkg::ENG_CONVERT;
                        idx_reg <= sar_adc_pkg::MSB_IDX;
                        code_reg <= sar_adc_pkg::bit_mask(sar_adc_pkg::MSB_IDX);
                     end else begin
                        cnt_reg <= cnt_reg + 2'h1;
                     end
                  end
               end
               sar_adc_pkg::ENG_CONVERT: begin
                  if (bus.tick) begin // see R18
                     if (idx_reg == 4'h0) begin
                        result_reg <= kept;
                        done_reg <= 1'b1;
                        code_reg <= sar_adc_pkg::CODE_RST;
                        state_reg <= sar_adc_pkg::ENG_IDLE;
                     end else begin
                        code_reg <= kept | sar_adc_pkg::bit_mask(idx_reg - 4'h1);
                        idx_reg <= idx_reg - 4'h1;
                     end
                  end
               end
               default: state_reg <= sar_adc_pkg::ENG_IDLE;
            endcase
         end
      end
   end
endmodule : sar_engine

// ==== verif/afe_model.sv ====
// Analog front end model: input mux, x8 amplifier, hold and comparator
`timescale 1ns/1ps
module afe_model (
   // Clock
   input wire logic clk,
   // Converter controls
   input wire logic adc_power,
   input wire logic amp_en,
   input wire logic [2:0] chan_sel,
   input wire logic sample_hold,
   input wire logic [9:0] dac_code,
   // Channel levels in code units, may leave the reference span
   input wire logic signed [15:0] ain [7],
   // Comparator
   output logic comp_in
);
   logic signed [19:0] held = 20'sh00000;
   logic idle_bit = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      idle_bit <= ~idle_bit;
      if (sample_hold && adc_power && chan_sel != 3'h7) begin
         held <= amp_en ? 20'(ain[chan_sel]) <<< 3 : 20'(ain[chan_sel]);
      end
   end

   // Unpowered comparator is meaningless, so it keeps moving
   assign comp_in = adc_power ? (held >= $signed({10'h000, dac_code})) : idle_bit;
endmodule : afe_model

// ==== verif/tb.sv ====
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module tb;
   logic clk;
   logic sys_rst;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic wait_mode;
   logic halt_mode;
   logic comp_in;
   logic [6:0] pin_in;
   logic adc_power;
   logic amp_en;
   logic [2:0] chan_sel;
   logic sample_hold;
   logic [9:0] dac_code;
   logic irq;
   logic signed [15:0] ain [7];
   int num_errors = 0;
   int n_compared = 0;
   int n;
   logic [7:0] v;

   ////////////////////////////////////////////////////////////////////////
   sar_adc_sequencer DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .wait_mode(wait_mode), .halt_mode(halt_mode),
      .comp_in(comp_in), .pin_in(pin_in), .adc_power(adc_power), .amp_en(amp_en),
      .chan_sel(chan_sel), .sample_hold(sample_hold), .dac_code(dac_code), .irq(irq));

   afe_model afe (.clk(clk), .adc_power(adc_power), .amp_en(amp_en), .chan_sel(chan_sel),
      .sample_hold(sample_hold), .dac_code(dac_code), .ain(ain), .comp_in(comp_in));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      bus_rd(a, d);
      chk(what, d, exp);
   endtask : rd_chk

   // Polls the done flag; cyc is the cycles spent, lim when it never came
   task automatic wait_done(input int lim, output int cyc);
      logic [7:0] d;
      cyc = 0;
      d = 8'h00;
      while (d[7] !== 1'b1 && cyc < lim) begin
         bus_rd(3'h0, d);
         cyc += 2;
      end
   endtask : wait_done

   task automatic ticks(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : ticks

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end

   initial begin
      sys_rst = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wait_mode = 1'b0;
      halt_mode = 1'b0;
      pin_in = 7'h00;
      foreach (ain[i]) ain[i] = 16'sh0000;
      ain[1] = 16'sd100;
      ain[2] = 16'sd695;
      ain[5] = 16'sd5000;
      ain[6] = -16'sd50;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset values, unmapped place included
      for (int a = 0; a < 8; a++) begin
         if (a != 5) rd_chk(3'(a), 8'h00, "reset value");
      end
      chk("power at reset", 8'(adc_power), 8'h00);
      pin_in <= 7'h5a;
      ticks(4);
      rd_chk(3'h3, 8'h5a, "pin levels");
      bus_wr(3'h3, 8'hff);
      rd_chk(3'h3, 8'h5a, "pin levels after write");
      // Continuous conversion, ten and eight bit reads
      bus_wr(3'h0, 8'h22);
      ticks(3);
      chk("power on", 8'(adc_power), 8'h01);
      chk("channel", 8'(chan_sel), 8'h02);
      wait_done(400, n);
      chk("first done", 8'(n < 400), 8'h01);
      rd_chk(3'h2, 8'h03, "low result");
      rd_chk(3'h1, 8'had, "high result");
      rd_chk(3'h0, 8'h22, "done after high read");
      wait_done(400, n);
      chk("next done", 8'(n < 400), 8'h01);
      rd_chk(3'h1, 8'had, "eight bit result");
      rd_chk(3'h0, 8'h22, "done after high read");
      wait_done(400, n);
      chk("masked request", 8'(irq), 8'h00);
      rd_chk(3'h4, 8'h01, "status");
      bus_wr(3'h0, 8'h22);
      rd_chk(3'h0, 8'h22, "done after ctrl write");
      // Interrupt raise, clear, mask
      bus_wr(3'h6, 8'h01);
      rd_chk(3'h6, 8'h01, "enable");
      wait_done(400, n);
      ticks(2);
      chk("request raised", 8'(irq), 8'h01);
      bus_wr(3'h5, 8'h03);
      ticks(2);
      chk("request cleared", 8'(irq), 8'h00);
      // Drop the done flag left from the last wait so a fresh completion is awaited
      bus_rd(3'h1, v);
      wait_done(400, n);
      ticks(2);
      chk("request again", 8'(irq), 8'h01);
      bus_wr(3'h6, 8'h00);
      ticks(2);
      chk("request masked", 8'(irq), 8'h00);
      bus_wr(3'h5, 8'h03);
      // Channel change in mid conversion, saturation both ways
      ticks(10);
      bus_wr(3'h0, 8'h25);
      rd_chk(3'h0, 8'h25, "done after channel change");
      bus_rd(3'h4, v);
      chk("abort status", 8'(v[1]), 8'h01);
      wait_done(400, n);
      rd_chk(3'h2, 8'h03, "saturated low");
      rd_chk(3'h1, 8'hff, "saturated high");
      bus_wr(3'h0, 8'h26);
      wait_done(400, n);
      rd_chk(3'h2, 8'h00, "zero low");
      rd_chk(3'h1, 8'h00, "zero high");
      // Amplifier
      bus_wr(3'h0, 8'h21);
      bus_wr(3'h2, 8'h10);
      ticks(2);
      chk("amplifier", 8'(amp_en), 8'h01);
      wait_done(400, n);
      bus_rd(3'h1, v);
      wait_done(400, n);
      chk("amplified done", 8'(n < 400), 8'h01);
      rd_chk(3'h2, 8'h10, "amplified low");
      rd_chk(3'h1, 8'hc8, "amplified high");
      bus_wr(3'h2, 8'h00);
      // Wait mode, halt mode, converter off
      wait_mode <= 1'b1;
      wait_done(400, n);
      chk("done in wait", 8'(n < 400), 8'h01);
      bus_wr(3'h0, 8'h21);
      halt_mode <= 1'b1;
      ticks(3);
      chk("power in halt", 8'(adc_power), 8'h00);
      // A completion may still land before the abort reaches the engine
      bus_rd(3'h1, v);
      wait_done(150, n);
      chk("no done in halt", 8'(n >= 150), 8'h01);
      halt_mode <= 1'b0;
      wait_done(400, n);
      // Stabilisation plus the shortest conversion must both have elapsed
      chk("stabilisation", 8'(n >= sar_adc_pkg::STAB_CYC + 12 * sar_adc_pkg::CONV_DIV
         && n < 400), 8'h01);
      bus_wr(3'h0, 8'h01);
      ticks(3);
      chk("power off", 8'(adc_power), 8'h00);
      bus_rd(3'h1, v);
      wait_done(200, n);
      chk("no done when off", 8'(n >= 200), 8'h01);
      finish_test();
   end
endmodule : tb
